//--- rtl/pef_params.svh
// constants for the phy event flag, interrupt control and page select block
// assumes a 5-bit management register address and 16-bit register data
`ifndef PEF_PARAMS_SVH
`define PEF_PARAMS_SVH
`define PEF_ADDR_ICR 5'h11
`define PEF_ADDR_FLAGS 5'h12
`define PEF_ADDR_PAGE 5'h13
`define PEF_ADDR_FCNT 5'h14
`define PEF_ADDR_RCNT 5'h15
`define PEF_FLAG_LSB 8
`define PEF_ICR_OE 0
`define PEF_ICR_GIE 1
`define PEF_ICR_TEST 2
`define PEF_EV_LQ 7
`define PEF_EV_ED 6
`define PEF_EV_LINK 5
`define PEF_EV_SPD 4
`define PEF_EV_DUP 3
`define PEF_EV_ANC 2
`define PEF_EV_FHF 1
`define PEF_EV_RHF 0
`define PEF_PAGE_EXT 2'h0
`define PEF_PAGE_RSVD 2'h1
`define PEF_PAGE_DIAG 2'h2
`define PEF_RST_EN 8'h00
`define PEF_RST_PAGE 2'h0
`define PEF_RST_ICR 3'h0
`define PEF_CNT_MAX 8'hff
`define PEF_CNT_HALF 8'h80
`endif

//--- rtl/pef_pkg.sv
// types shared by the event flag block and its helpers
// assumes pef_params.svh is on the include path
`include "pef_params.svh"
package pef_pkg;
  typedef logic [7:0] pef_ev_t;
  // top-level register and pin state
  typedef struct packed {
    logic [2:0] icr;
    pef_ev_t en;
    logic [1:0] page;
    logic [15:0] rdata;
    logic irq;
    logic pin_o;
    logic pin_oe_n;
    logic pd;
  } pef_top_s;
  typedef struct packed {
    pef_ev_t flags;
  } pef_bank_s;
  typedef struct packed {
    logic [7:0] count;
    logic half;
  } pef_cnt_s;
  // address match qualified by a strobe
  function automatic logic pef_hit(input logic [4:0] a, input logic [4:0] t, input logic s);
    return s && (a == t);
  endfunction
endpackage

//--- rtl/pef_flag_if.sv
// carrier between the register front end and the sticky flag bank
// assumes one clock domain; no clocking block
`timescale 1ns/1ps
interface pef_flag_if;
  logic [7:0] set;
  logic clr;
  logic [7:0] flags;
  modport bank (input set, input clr, output flags);
  modport user (output set, output clr, input flags);
endinterface // pef_flag_if

//--- rtl/pef_flag_bank.sv
// eight sticky event flags, cleared together by a read
// assumes set is a per-cycle event vector and clr a one-cycle read strobe
`timescale 1ns/1ps
module pef_flag_bank
  import pef_pkg::*;
(
  input wire logic ref_clk, // device clock
  input wire logic rst, // sync reset, active high
  input wire logic ce, // clock enable
  pef_flag_if.bank fi // set, clear and flag view
);
  pef_bank_s s_q, s_d;
  // set beats clear so an event during the read waits for the next read
  always_comb begin
    s_d = s_q;
    s_d.flags = (s_q.flags & {8{~fi.clr}}) | fi.set;
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
  assign fi.flags = s_q.flags;
  property p_set_sticky;
    @(posedge ref_clk) disable iff (rst)
      (ce && |fi.set) |=> ((fi.flags & $past(fi.set)) == $past(fi.set));
  endproperty
  a_set_sticky: assert property (p_set_sticky) else $error("event lost in flag bank");
  property p_read_clears;
    @(posedge ref_clk) disable iff (rst)
      (ce && fi.clr && fi.set == 8'h00) |=> (fi.flags == 8'h00);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flags not cleared by read");
endmodule // pef_flag_bank

//--- rtl/pef_err_cnt.sv
// 8-bit saturating error counter, clear on read, half-full event
// assumes inc is one pulse per counted error
`timescale 1ns/1ps
module pef_err_cnt
  import pef_pkg::*;
(
  input wire logic ref_clk, // device clock
  input wire logic rst, // sync reset, active high
  input wire logic ce, // clock enable
  input wire logic inc, // one error seen
  input wire logic clr, // read of the counter
  output logic [7:0] count, // current count
  output logic half // pulse on reaching half full
);
  pef_cnt_s s_q, s_d;
  // an error in the read cycle counts as the first of the new run
  always_comb begin
    s_d = s_q;
    if (clr) begin
      s_d.count = {7'h00, inc};
    end else if (inc && s_q.count != `PEF_CNT_MAX) begin
      s_d.count = s_q.count + 8'h01;
    end
    s_d.half = (s_d.count == `PEF_CNT_HALF) && (s_q.count != `PEF_CNT_HALF);
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
  assign count = s_q.count;
  assign half = s_q.half && ce;
  property p_sat;
    @(posedge ref_clk) disable iff (rst)
      (ce && count == 8'hff && !clr) |=> (count == 8'hff);
  endproperty
  a_sat: assert property (p_sat) else $error("counter left saturation");
  property p_half;
    @(posedge ref_clk) disable iff (rst)
      half |-> (count == 8'h80 && $past(count) == 8'h7f);
  endproperty
  a_half: assert property (p_half) else $error("half-full event at wrong count");
endmodule // pef_err_cnt

//--- rtl/pef_event_flags.sv
// event flag and enable register, interrupt control and page select
// of one transceiver port, with the two half-full error counters.
// assumes the management frame engine delivers one-cycle read and
// write strobes with a 5-bit register address and 16-bit data.
`timescale 1ns/1ps
`include "pef_params.svh"
module pef_event_flags
  import pef_pkg::*;
(
  input wire logic ref_clk, // 100 mhz device clock
  input wire logic rst, // sync reset, active high
  input wire logic ce, // clock enable, freezes all
  input wire logic [4:0] mgmt_addr, // register address
  input wire logic mgmt_rd, // read strobe
  input wire logic mgmt_wr, // write strobe
  input wire logic [15:0] mgmt_wdata, // write data
  output logic [15:0] mgmt_rdata, // read data, held
  input wire logic ev_link_quality, // link quality event
  input wire logic ev_energy, // energy detect event
  input wire logic ev_link_change, // link status change
  input wire logic ev_speed, // speed status change
  input wire logic ev_duplex, // duplex status change
  input wire logic ev_autoneg_done, // autoneg complete
  input wire logic ev_false_carrier, // one false carrier
  input wire logic ev_rx_error, // one receive error
  input wire logic pin_i, // shared pin level in
  output logic pin_o, // shared pin, irq high
  output logic pin_oe_n, // low while pin driven
  output logic powerdown_req, // pin sampled as input
  output logic [1:0] page_sel // page for 14h-1fh
);
  pef_top_s s_q;
  pef_top_s s_d;
  pef_flag_if fi();
  logic [7:0] fcnt;
  logic [7:0] rcnt;
  logic fhalf;
  logic rhalf;
  logic rd_flags;
  logic rd_fcnt;
  logic rd_rcnt;
  logic page_ext;
  logic ev_pend;
  logic gie;
  logic forced_test_irq;

  // counters live on the extended page only, so their reads
  // only clear them when that page is selected
  assign page_ext = (s_q.page == `PEF_PAGE_EXT);
  assign rd_flags = pef_hit(mgmt_addr, `PEF_ADDR_FLAGS, mgmt_rd);
  assign rd_fcnt = pef_hit(mgmt_addr, `PEF_ADDR_FCNT, mgmt_rd) && page_ext;
  assign rd_rcnt = pef_hit(mgmt_addr, `PEF_ADDR_RCNT, mgmt_rd) && page_ext;

  pef_err_cnt u_fcnt (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .inc(ev_false_carrier),
    .clr(rd_fcnt),
    .count(fcnt),
    .half(fhalf)
  );

  pef_err_cnt u_rcnt (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .inc(ev_rx_error),
    .clr(rd_rcnt),
    .count(rcnt),
    .half(rhalf)
  );

  pef_flag_bank u_bank (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .fi(fi.bank)
  );

  // event vector in flag bit order, never gated by any enable
  always_comb begin
    fi.set = 8'h00;
    fi.set[`PEF_EV_LQ] = ev_link_quality;
    fi.set[`PEF_EV_ED] = ev_energy;
    fi.set[`PEF_EV_LINK] = ev_link_change;
    fi.set[`PEF_EV_SPD] = ev_speed;
    fi.set[`PEF_EV_DUP] = ev_duplex;
    fi.set[`PEF_EV_ANC] = ev_autoneg_done;
    fi.set[`PEF_EV_FHF] = fhalf;
    fi.set[`PEF_EV_RHF] = rhalf;
  end

  // a read of the flag register clears every flag not set again in the same cycle
  assign fi.clr = rd_flags;

  assign gie = s_q.icr[`PEF_ICR_GIE];
  assign forced_test_irq = s_q.icr[`PEF_ICR_TEST];
  // request is level: with gie set it stays up while an enabled flag is pending
  assign ev_pend = |(fi.flags & s_q.en);

  // register writes, read mux and pin control
  always_comb begin
    s_d = s_q;
    if (pef_hit(mgmt_addr, `PEF_ADDR_ICR, mgmt_wr)) begin
      s_d.icr = mgmt_wdata[2:0];
    end
    if (pef_hit(mgmt_addr, `PEF_ADDR_FLAGS, mgmt_wr)) begin
      s_d.en = mgmt_wdata[7:0];
    end
    // upper bits dropped; reserved code 1 is stored as written
    if (pef_hit(mgmt_addr, `PEF_ADDR_PAGE, mgmt_wr)) begin
      s_d.page = mgmt_wdata[1:0];
    end
    if (mgmt_rd) begin
      unique case (mgmt_addr)
        `PEF_ADDR_ICR: begin
          s_d.rdata = {13'h0000, s_q.icr};
        end
        `PEF_ADDR_FLAGS: begin
          s_d.rdata = {fi.flags, s_q.en};
        end
        `PEF_ADDR_PAGE: begin
          s_d.rdata = {14'h0000, s_q.page};
        end
        `PEF_ADDR_FCNT: begin
          s_d.rdata = page_ext ? {8'h00, fcnt} : 16'h0000;
        end
        `PEF_ADDR_RCNT: begin
          s_d.rdata = page_ext ? {8'h00, rcnt} : 16'h0000;
        end
        default: begin
          s_d.rdata = 16'h0000;
        end
      endcase
    end
    // test bit bypasses both enables so the pin path can be proven
    s_d.irq = forced_test_irq || (gie && ev_pend);
    s_d.pin_oe_n = ~s_q.icr[`PEF_ICR_OE];
    s_d.pin_o = s_q.icr[`PEF_ICR_OE] && s_d.irq;
    s_d.pd = ~s_q.icr[`PEF_ICR_OE] && pin_i;
  end

  // one register for all front-end state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q.icr <= `PEF_RST_ICR;
      s_q.en <= `PEF_RST_EN;
      s_q.page <= `PEF_RST_PAGE;
      s_q.rdata <= 16'h0000;
      s_q.irq <= 1'b0;
      s_q.pin_o <= 1'b0;
      s_q.pin_oe_n <= 1'b1;
      s_q.pd <= 1'b0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign mgmt_rdata = s_q.rdata;
  assign pin_o = s_q.pin_o;
  assign pin_oe_n = s_q.pin_oe_n;
  assign powerdown_req = s_q.pd;
  assign page_sel = s_q.page;

  // checks

  sequence s_flags_rd;
    ce && rd_flags;
  endsequence

  property p_flags_read;
    @(posedge ref_clk) disable iff (rst)
      s_flags_rd |=> (mgmt_rdata == {$past(fi.flags), $past(s_q.en)});
  endproperty
  a_flags_read: assert property (p_flags_read) else $error("flag read data wrong");

  property p_flags_gone;
    @(posedge ref_clk) disable iff (rst)
      (s_flags_rd and (fi.set == 8'h00)) |=> (fi.flags == 8'h00);
  endproperty
  a_flags_gone: assert property (p_flags_gone) else $error("flags kept after read");

  property p_enable_wr;
    @(posedge ref_clk) disable iff (rst)
      (ce && pef_hit(mgmt_addr, `PEF_ADDR_FLAGS, mgmt_wr)) |=> (s_q.en == $past(mgmt_wdata[7:0]));
  endproperty
  a_enable_wr: assert property (p_enable_wr) else $error("enable write lost");

  property p_event_irq;
    @(posedge ref_clk) disable iff (rst)
      (ce && gie && ev_pend) |=> s_q.irq;
  endproperty
  a_event_irq: assert property (p_event_irq) else $error("enabled event gave no request");

  property p_gie_gate;
    @(posedge ref_clk) disable iff (rst)
      (ce && !gie && !forced_test_irq) |=> !s_q.irq;
  endproperty
  a_gie_gate: assert property (p_gie_gate) else $error("request without global enable");

  property p_masked;
    @(posedge ref_clk) disable iff (rst)
      (ce && !forced_test_irq && !ev_pend) |=> !s_q.irq;
  endproperty
  a_masked: assert property (p_masked) else $error("request from disabled event");

  property p_test_irq;
    @(posedge ref_clk) disable iff (rst)
      (ce && forced_test_irq) [*2] |=> (s_q.irq && pin_o == $past(s_q.icr[`PEF_ICR_OE]));
  endproperty
  a_test_irq: assert property (p_test_irq) else $error("test request not held");

  property p_pin_dir;
    @(posedge ref_clk) disable iff (rst)
      ce |=> (pin_oe_n == !$past(s_q.icr[`PEF_ICR_OE]) && !(pin_oe_n && pin_o));
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("pin direction wrong");

  property p_page_read;
    @(posedge ref_clk) disable iff (rst)
      (ce && pef_hit(mgmt_addr, `PEF_ADDR_PAGE, mgmt_rd)) |=> (mgmt_rdata[15:2] == 14'h0000);
  endproperty
  a_page_read: assert property (p_page_read) else $error("page reserved bits not zero");

  property p_page_wr;
    @(posedge ref_clk) disable iff (rst)
      (ce && pef_hit(mgmt_addr, `PEF_ADDR_PAGE, mgmt_wr)) |=> (page_sel == $past(mgmt_wdata[1:0]));
  endproperty
  a_page_wr: assert property (p_page_wr) else $error("page write lost");

  property p_diag_cnt;
    @(posedge ref_clk) disable iff (rst)
      (ce && mgmt_rd && mgmt_addr == `PEF_ADDR_FCNT && s_q.page == `PEF_PAGE_DIAG) |=> (mgmt_rdata == 16'h0000);
  endproperty
  a_diag_cnt: assert property (p_diag_cnt) else $error("counter seen on diag page");

  property p_icr_read;
    @(posedge ref_clk) disable iff (rst)
      (ce && pef_hit(mgmt_addr, `PEF_ADDR_ICR, mgmt_rd)) |=> (mgmt_rdata == {13'h0000, $past(s_q.icr)});
  endproperty
  a_icr_read: assert property (p_icr_read) else $error("control read data wrong");

  property p_icr_wr;
    @(posedge ref_clk) disable iff (rst)
      (ce && pef_hit(mgmt_addr, `PEF_ADDR_ICR, mgmt_wr)) |=> (s_q.icr == $past(mgmt_wdata[2:0]));
  endproperty
  a_icr_wr: assert property (p_icr_wr) else $error("control write lost");

  property p_page_val;
    @(posedge ref_clk) disable iff (rst)
      (ce && pef_hit(mgmt_addr, `PEF_ADDR_PAGE, mgmt_rd)) |=> (mgmt_rdata[1:0] == $past(s_q.page));
  endproperty
  a_page_val: assert property (p_page_val) else $error("page read value wrong");

  // counter reads only count on the extended page
  property p_fcnt_read;
    @(posedge ref_clk) disable iff (rst)
      (ce && rd_fcnt) |=> (mgmt_rdata == {8'h00, $past(fcnt)});
  endproperty
  a_fcnt_read: assert property (p_fcnt_read) else $error("false carrier count read wrong");

  property p_rcnt_read;
    @(posedge ref_clk) disable iff (rst)
      (ce && rd_rcnt) |=> (mgmt_rdata == {8'h00, $past(rcnt)});
  endproperty
  a_rcnt_read: assert property (p_rcnt_read) else $error("rx error count read wrong");

  property p_pd_in;
    @(posedge ref_clk) disable iff (rst)
      ce |=> (powerdown_req == ($past(pin_i) && !$past(s_q.icr[`PEF_ICR_OE])));
  endproperty
  a_pd_in: assert property (p_pd_in) else $error("powerdown input path wrong");

  // each event lands in its own flag bit one edge later
  property p_lq_flag;
    @(posedge ref_clk) disable iff (rst)
      (ce && ev_link_quality) |=> fi.flags[`PEF_EV_LQ];
  endproperty
  a_lq_flag: assert property (p_lq_flag) else $error("link quality flag missed");

  property p_ed_flag;
    @(posedge ref_clk) disable iff (rst)
      (ce && ev_energy) |=> fi.flags[`PEF_EV_ED];
  endproperty
  a_ed_flag: assert property (p_ed_flag) else $error("energy flag missed");

  property p_link_flag;
    @(posedge ref_clk) disable iff (rst)
      (ce && ev_link_change) |=> fi.flags[`PEF_EV_LINK];
  endproperty
  a_link_flag: assert property (p_link_flag) else $error("link change flag missed");

  property p_spd_flag;
    @(posedge ref_clk) disable iff (rst)
      (ce && ev_speed) |=> fi.flags[`PEF_EV_SPD];
  endproperty
  a_spd_flag: assert property (p_spd_flag) else $error("speed change flag missed");

  property p_dup_flag;
    @(posedge ref_clk) disable iff (rst)
      (ce && ev_duplex) |=> fi.flags[`PEF_EV_DUP];
  endproperty
  a_dup_flag: assert property (p_dup_flag) else $error("duplex change flag missed");

  property p_anc_flag;
    @(posedge ref_clk) disable iff (rst)
      (ce && ev_autoneg_done) |=> fi.flags[`PEF_EV_ANC];
  endproperty
  a_anc_flag: assert property (p_anc_flag) else $error("autoneg done flag missed");

  property p_fhf_flag;
    @(posedge ref_clk) disable iff (rst)
      (ce && fhalf) |=> fi.flags[`PEF_EV_FHF];
  endproperty
  a_fhf_flag: assert property (p_fhf_flag) else $error("false carrier half flag missed");

  property p_rhf_flag;
    @(posedge ref_clk) disable iff (rst)
      (ce && rhalf) |=> fi.flags[`PEF_EV_RHF];
  endproperty
  a_rhf_flag: assert property (p_rhf_flag) else $error("rx error half flag missed");

  // without an event or a read the flags must not move
  property p_flags_quiet;
    @(posedge ref_clk) disable iff (rst)
      (ce && !mgmt_rd && fi.set == 8'h00) |=> $stable(fi.flags);
  endproperty
  a_flags_quiet: assert property (p_flags_quiet) else $error("flags changed without cause");

  property p_page_keep;
    @(posedge ref_clk) disable iff (rst)
      (ce && !pef_hit(mgmt_addr, `PEF_ADDR_PAGE, mgmt_wr)) |=> $stable(page_sel);
  endproperty
  a_page_keep: assert property (p_page_keep) else $error("page changed without write");

  property p_en_keep;
    @(posedge ref_clk) disable iff (rst)
      (ce && !pef_hit(mgmt_addr, `PEF_ADDR_FLAGS, mgmt_wr)) |=> $stable(s_q.en);
  endproperty
  a_en_keep: assert property (p_en_keep) else $error("enables changed without write");
endmodule // pef_event_flags

//--- tb/pef_mgmt_model.sv
// management station model issuing one-cycle read and write strobes
// assumes the block takes a strobe at a rising edge and answers one cycle later
`timescale 1ns/1ps
module pef_mgmt_model (
  input wire logic ref_clk, // device clock
  output logic [4:0] mgmt_addr, // register address
  output logic mgmt_rd, // read strobe
  output logic mgmt_wr, // write strobe
  output logic [15:0] mgmt_wdata, // write data
  input wire logic [15:0] mgmt_rdata // read data from block
);
  // idle bus state
  initial begin
    mgmt_addr = 5'h1f;
    mgmt_rd = 1'b0;
    mgmt_wr = 1'b0;
    mgmt_wdata = 16'h0000;
  end

  // one write strobe; address and data are inverted after release so stale values never match
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    mgmt_wr <= 1'b1;
    mgmt_addr <= a;
    mgmt_wdata <= d;
    @(posedge ref_clk);
    mgmt_wr <= 1'b0;
    mgmt_addr <= ~a;
    mgmt_wdata <= ~d;
    #1;
  endtask

  // one read strobe; data is taken once the answering edge has landed
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    mgmt_rd <= 1'b1;
    mgmt_addr <= a;
    @(posedge ref_clk);
    mgmt_rd <= 1'b0;
    mgmt_addr <= ~a;
    #1;
    d = mgmt_rdata;
  endtask
endmodule // pef_mgmt_model

//--- tb/tb_pef_event_flags.sv
// self-checking bench for the event flag, interrupt control and page block
// assumes the management model drives the strobe port; events come from here
`timescale 1ns/1ps
module tb_pef_event_flags;
  import pef_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic pin_i = 1'b0;
  logic [7:0] ev = 8'h00;
  logic [4:0] mgmt_addr;
  logic mgmt_rd;
  logic mgmt_wr;
  logic [15:0] mgmt_wdata;
  logic [15:0] mgmt_rdata;
  logic pin_o;
  logic pin_oe_n;
  logic powerdown_req;
  logic [1:0] page_sel;
  int miscompares = 0;
  int total_checks = 0;

  // 100 mhz device clock
  always #5 ref_clk = ~ref_clk;

  pef_event_flags pef_event_flags_i (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .mgmt_addr(mgmt_addr),
    .mgmt_rd(mgmt_rd),
    .mgmt_wr(mgmt_wr),
    .mgmt_wdata(mgmt_wdata),
    .mgmt_rdata(mgmt_rdata),
    .ev_link_quality(ev[7]),
    .ev_energy(ev[6]),
    .ev_link_change(ev[5]),
    .ev_speed(ev[4]),
    .ev_duplex(ev[3]),
    .ev_autoneg_done(ev[2]),
    .ev_false_carrier(ev[1]),
    .ev_rx_error(ev[0]),
    .pin_i(pin_i),
    .pin_o(pin_o),
    .pin_oe_n(pin_oe_n),
    .powerdown_req(powerdown_req),
    .page_sel(page_sel)
  );

  pef_mgmt_model pef_mgmt_model_i (
    .ref_clk(ref_clk),
    .mgmt_addr(mgmt_addr),
    .mgmt_rd(mgmt_rd),
    .mgmt_wr(mgmt_wr),
    .mgmt_wdata(mgmt_wdata),
    .mgmt_rdata(mgmt_rdata)
  );

  // single compare point, counts every check
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] v;
    pef_mgmt_model_i.rd(a, v);
    check(v, exp);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    pef_mgmt_model_i.wr(a, d);
  endtask

  // hold one event line high for n sampled cycles
  task automatic pulse(input int b, input int n);
    @(posedge ref_clk);
    ev[b] <= 1'b1;
    repeat (n) @(posedge ref_clk);
    ev[b] <= 1'b0;
  endtask

  // lets the flag and then the pin register update before looking
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  task automatic give_verdict();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // watchdog: the sequence needs about 860 cycles
  initial begin
    #50000;
    miscompares++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    rd_chk(5'h11, 16'h0000);
    rd_chk(5'h12, 16'h0000);
    rd_chk(5'h13, 16'h0000);
    check({15'h0000, pin_oe_n}, 16'h0001);
    // page field: only two bits stick
    wr(5'h13, 16'hffff);
    rd_chk(5'h13, 16'h0003);
    wr(5'h13, 16'h0002);
    check({14'h0000, page_sel}, 16'h0002);
    wr(5'h13, 16'h0000);
    check({14'h0000, page_sel}, 16'h0000);
    // each status event with all enables off, then cleared by the read
    for (int b = 7; b >= 2; b--) begin
      pulse(b, 1);
      rd_chk(5'h12, 16'h0001 << (b + 8));
      rd_chk(5'h12, 16'h0000);
    end
    // flag half is not writable, enables are
    wr(5'h12, 16'hffff);
    rd_chk(5'h12, 16'h00ff);
    wr(5'h11, 16'h0003);
    settle();
    check({15'h0000, pin_oe_n}, 16'h0000);
    pulse(5, 1);
    settle();
    check({15'h0000, pin_o}, 16'h0001);
    rd_chk(5'h12, 16'h20ff);
    settle();
    check({15'h0000, pin_o}, 16'h0000);
    // per-event enable off: flag only
    wr(5'h12, 16'h0000);
    pulse(4, 1);
    settle();
    check({15'h0000, pin_o}, 16'h0000);
    rd_chk(5'h12, 16'h1000);
    // global enable off: flag only
    wr(5'h12, 16'h00ff);
    wr(5'h11, 16'h0001);
    pulse(3, 1);
    settle();
    check({15'h0000, pin_o}, 16'h0000);
    rd_chk(5'h12, 16'h08ff);
    wr(5'h11, 16'h0005);
    settle();
    check({15'h0000, pin_o}, 16'h0001);
    // output enable off: pin becomes the powerdown input
    wr(5'h11, 16'h0004);
    @(posedge ref_clk);
    pin_i <= 1'b1;
    settle();
    check({14'h0000, pin_o, pin_oe_n}, 16'h0001);
    check({15'h0000, powerdown_req}, 16'h0001);
    // counters: half flag at 80h, saturation at ffh
    pulse(1, 127);
    rd_chk(5'h12, 16'h00ff);
    pulse(1, 1);
    rd_chk(5'h12, 16'h02ff);
    rd_chk(5'h14, 16'h0080);
    pulse(0, 300);
    rd_chk(5'h15, 16'h00ff);
    rd_chk(5'h12, 16'h01ff);
    pulse(1, 300);
    // diagnostics page hides the counter and its read must not clear it
    wr(5'h13, 16'h0002);
    rd_chk(5'h14, 16'h0000);
    wr(5'h13, 16'h0000);
    rd_chk(5'h14, 16'h00ff);
    give_verdict();
  end
endmodule // tb_pef_event_flags
